// ===== src/flash_auto_erase_and_abort_sequencer.sv
// command decoder and auto-erase / abort sequencer of the flash control unit
`timescale 1ns/100ps
// Contract
// - two consecutive auto-erase code writes start auto erase on the selected area.
// - auto erase first writes zero bytes to every location of the area.
// - verify checks each address, and on a failure erases again and restarts verify.
// - auto erase ends only when every address verified erased.
// - busy goes high when auto erase starts and low when it completes.
// - the watchdog is held at all ones while auto erase runs.
// - two abort codes after a program, erase or auto code cancel it and reset.
// - the abort sequence leaves the stored contents unchanged.
// - busy sits in control bit one and is set only during auto erase.
// - control bits four and five select the area acted upon.
// - after abort the device is in read mode.
module flash_auto_erase_and_abort_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W       = DEF_ADDR_W,
  parameter int ERASE_CNT    = ERASE_CYCLES
) (
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic              cmd_we_in,
  input  wire logic [7:0]        cmd_data_in,
  input  wire logic [7:0]        ctrl_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0]             rd_data_out,
  output logic [7:0]             ctrl_status_out,
  output logic                   busy_out,
  output logic                   read_mode_out,
  output logic                   wdt_hold_out,
  output logic [7:0]             wdt_value_out
);
  typedef enum {ST_READ, ST_PENDING, ST_ARMED, ST_FILL, ST_ERASE, ST_VERIFY} state_type;

  localparam int LAST = (1 << ADDR_W) - 1;

  state_type         state;
  logic [7:0]        first_code;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       erase_cnt;
  logic [1:0]        area;
  logic              busy;

  flash_array_if #(.ADDR_W(ADDR_W)) arr ();

  // the pulse counter is 16 bits wide, so longer pulses cannot be counted
  if (ERASE_CNT < 1 || ERASE_CNT > 65535) begin : g_erase_cnt_check
    $error("ERASE_CNT out of range");
  end

  flash_store #(.ADDR_W(ADDR_W)) store (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .port_in     (arr.array),
    .rd_addr_in  (rd_addr_in),
    .rd_data_out (rd_data_out)
  );

  // ****************************************************************
  // command decode and sequencing
  // ****************************************************************
  function automatic logic is_armable(input logic [7:0] c);
    return (c == CMD_PROGRAM) || (c == CMD_ERASE) || (c == CMD_AUTO);
  endfunction

  // area is latched at start so a later control write cannot move a running erase
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state      <= ST_READ;
      first_code <= CMD_READ;
      addr       <= '0;
      erase_cnt  <= '0;
      area       <= '0;
    end else begin
      case (state)
        ST_READ: begin
          if (cmd_we_in && is_armable(cmd_data_in)) begin
            first_code <= cmd_data_in;
            state      <= ST_PENDING;
          end
        end
        ST_PENDING: begin
          if (cmd_we_in) begin
            if (cmd_data_in == CMD_ABORT) begin
              state <= ST_ARMED;
            end else if (cmd_data_in == first_code && first_code == CMD_AUTO) begin
              area  <= ctrl_in[AREA_HI_BIT:AREA_LO_BIT];
              addr  <= '0;
              state <= ST_FILL;
            end else begin
              state <= ST_READ;
            end
          end
        end
        ST_ARMED: begin
          // second abort completes the cancel; anything else drops it too
          if (cmd_we_in) state <= ST_READ;
        end
        ST_FILL: begin
          addr <= addr + 1'b1;
          if (addr == ADDR_W'(LAST)) begin
            erase_cnt <= 16'(ERASE_CNT - 1);
            state     <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          if (erase_cnt == 16'h0000) begin
            addr  <= '0;
            state <= ST_VERIFY;
          end else begin
            erase_cnt <= erase_cnt - 1'b1;
          end
        end
        ST_VERIFY: begin
          if (arr.rd_data != ERASED_BYTE) begin
            erase_cnt <= 16'(ERASE_CNT - 1);
            state     <= ST_ERASE;
          end else if (addr == ADDR_W'(LAST)) begin
            state <= ST_READ;
          end else begin
            addr <= addr + 1'b1;
          end
        end
        default: state <= ST_READ;
      endcase
    end
  end

  // array drive: only fill and erase touch the array, abort states never do
  assign arr.wr_en    = (state == ST_FILL);
  assign arr.wr_data  = ZERO_BYTE;
  assign arr.erase_en = (state == ST_ERASE) && (erase_cnt == 16'h0000);
  assign arr.addr     = addr;
  assign arr.area     = area;

  // ****************************************************************
  // busy flag and watchdog hold
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) busy <= 1'b0;
    else busy <= (state == ST_PENDING && cmd_we_in && cmd_data_in == CMD_AUTO &&
                  first_code == CMD_AUTO) ||
                 (busy && !(state == ST_VERIFY && arr.rd_data == ERASED_BYTE &&
                            addr == ADDR_W'(LAST)));
  end

  assign busy_out      = busy;
  assign read_mode_out = (state == ST_READ);
  assign wdt_hold_out  = busy;
  assign wdt_value_out = busy ? WDT_PRESET : 8'h00;

  // status view of the control register with busy in its bit
  always_comb begin
    ctrl_status_out           = ctrl_in;
    ctrl_status_out[BUSY_BIT] = busy;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  busy_start_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(state == ST_FILL) |-> busy)
    else $error("busy not set at auto erase start");
  fill_zero_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    arr.wr_en |-> (arr.wr_data == 8'h00 && state == ST_FILL))
    else $error("fill wrote non-zero");
  fill_span_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(state == ST_FILL) |-> addr == '0)
    else $error("fill did not start at zero");
  verify_fail_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_VERIFY && arr.rd_data != 8'hff) |=> state == ST_ERASE)
    else $error("verify failure did not re-erase");
  done_ok_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(busy) |-> $past(state) == ST_VERIFY && $past(addr) == ADDR_W'(LAST))
    else $error("auto erase ended before full verify");
  wdt_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_FILL || state == ST_ERASE || state == ST_VERIFY) |->
      wdt_hold_out && wdt_value_out == 8'hff)
    else $error("watchdog not held");
  abort_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_ARMED && cmd_we_in) |=> read_mode_out && !busy)
    else $error("abort did not return to read");
  abort_safe_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_PENDING || state == ST_ARMED) |-> !arr.wr_en && !arr.erase_en)
    else $error("array touched during command decode");
  mismatch_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == ST_PENDING && cmd_we_in && cmd_data_in != first_code &&
     cmd_data_in != 8'hff) |=> state == ST_READ)
    else $error("mismatched second write not discarded");
endmodule

// ===== shared/flash_seq_pkg.sv
// package of codes, field positions and counts for the flash command sequencer
package flash_seq_pkg;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_PROGRAM   = 8'h40;
  localparam logic [7:0] CMD_ERASE     = 8'h20;
  localparam logic [7:0] CMD_AUTO      = 8'h30;
  localparam logic [7:0] CMD_ABORT     = 8'hff;
  // ****************************************************************
  // data patterns and control register fields
  // ****************************************************************
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam logic [7:0] WDT_PRESET    = 8'hff;
  localparam int         BUSY_BIT      = 1;
  localparam int         AREA_LO_BIT   = 4;
  localparam int         AREA_HI_BIT   = 5;
  localparam int         AREA_W        = 2;
  // ****************************************************************
  // timing: erase pulse length
  // ****************************************************************
  localparam int         CLOCK_MHZ     = 40;
  localparam int         ERASE_US      = 10;
  localparam int         ERASE_CYCLES  = ERASE_US * CLOCK_MHZ;
  localparam int         DEF_ADDR_W    = 4;
endpackage

// ===== shared/flash_array_if.sv
// interface between the sequencer and the flash array port
`timescale 1ns/100ps
interface flash_array_if #(parameter int ADDR_W = 4);
  logic              wr_en;
  logic              erase_en;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wr_data;
  logic [7:0]        rd_data;
  logic [1:0]        area;
  modport seq   (output wr_en, output erase_en, output addr, output wr_data, output area,
                 input rd_data);
  modport array (input wr_en, input erase_en, input addr, input wr_data, input area,
                 output rd_data);
endinterface

// ===== src/flash_store.sv
// flip-flop flash array model of all four areas, one region per area code
`timescale 1ns/100ps
module flash_store
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
) (
  input  wire logic   clock_in,
  input  wire logic   rstn_in,
  flash_array_if.array port_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0]  rd_data_out
);
  localparam int WORDS = 1 << ADDR_W;
  logic [7:0] mem [4*WORDS];
  logic [ADDR_W+1:0] base;

  // the base concatenation and the flat index stop making sense outside this span
  if (ADDR_W < 1 || ADDR_W > 12) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  assign base = {port_in.area, {ADDR_W{1'b0}}};

  // storage: writes only clear bits like real flash, erase sets the whole area
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 4*WORDS; i++) mem[i] <= ERASED_BYTE;
    end else if (port_in.erase_en) begin
      for (int i = 0; i < WORDS; i++) mem[int'(base) + i] <= ERASED_BYTE;
    end else if (port_in.wr_en) begin
      mem[{port_in.area, port_in.addr}] <= mem[{port_in.area, port_in.addr}] & port_in.wr_data;
    end
  end

  assign port_in.rd_data = mem[{port_in.area, port_in.addr}];

  // cpu read port, registered
  always_ff @(posedge clock_in) begin
    if (!rstn_in) rd_data_out <= 8'h00;
    else rd_data_out <= mem[{port_in.area, rd_addr_in}];
  end
endmodule

// ===== testbench/cpu_model.sv
// cpu model issuing flash command register writes and polling busy
`timescale 1ns/100ps
module cpu_model (
  input  wire logic       clock_in,
  input  wire logic       busy_in,
  output logic            cmd_we_out,
  output logic [7:0]      cmd_data_out
);
  // ****************************************************************
  // command writes and busy polling
  // ****************************************************************
  initial begin
    cmd_we_out = 1'b0;
    cmd_data_out = 8'h00;
  end
  // back-to-back writes, changed at the falling edge so the rising edge sees them settled
  task automatic write_seq(input logic [7:0] codes[$]);
    foreach (codes[i]) begin
      @(negedge clock_in);
      cmd_we_out = 1'b1;
      cmd_data_out = codes[i];
    end
    @(negedge clock_in);
    cmd_we_out = 1'b0;
    cmd_data_out = ~cmd_data_out; // stale code is not left on the bus
  endtask
  // poll until busy reads zero, giving up after 1000 cycles; cycles counts the falling edges waited
  task automatic poll(output int cycles);
    cycles = 0;
    while (busy_in === 1'b1 && cycles < 1000) begin
      @(negedge clock_in);
      cycles++;
    end
  endtask
endmodule

// ===== testbench/tb_flash_auto_erase_and_abort_sequencer.sv
// self-checking bench of the auto-erase and abort sequencer
`timescale 1ns/100ps
module tb_flash_auto_erase_and_abort_sequencer;
  import flash_seq_pkg::*;
  localparam int AW = 4;
  localparam int EN = 2;
  logic          clock_in = 1'b0;
  logic          rstn_in = 1'b0;
  logic          cmd_we;
  logic [7:0]    cmd_data;
  logic [7:0]    ctrl_in = 8'h00;
  logic [AW-1:0] rd_addr_in = '0;
  logic [7:0]    rd_data, ctrl_status, wdt_value;
  logic          busy, read_mode, wdt_hold;
  int            miscompares = 0;
  int            compares = 0;
  // ****************************************************************
  // clock, design and cpu model
  // ****************************************************************
  initial forever #12.5 clock_in = ~clock_in;
  // short erase pulse keeps the run brief
  flash_auto_erase_and_abort_sequencer #(.ADDR_W(AW), .ERASE_CNT(EN)) u_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .cmd_we_in(cmd_we), .cmd_data_in(cmd_data),
    .ctrl_in(ctrl_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data),
    .ctrl_status_out(ctrl_status), .busy_out(busy), .read_mode_out(read_mode),
    .wdt_hold_out(wdt_hold), .wdt_value_out(wdt_value));
  cpu_model u_cpu (.clock_in(clock_in), .busy_in(busy), .cmd_we_out(cmd_we),
    .cmd_data_out(cmd_data));
  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle state: not busy, read mode, watchdog free, busy bit clear in status
  task automatic check_idle();
    check({7'h0, busy}, 8'h00);
    check({7'h0, read_mode}, 8'h01);
    check({7'h0, wdt_hold}, 8'h00);
    check(ctrl_status, {ctrl_in[7:2], 1'b0, ctrl_in[0]});
  endtask
  // every location of the area reads erased; read data lags the address by one cycle
  task automatic check_array();
    for (int a = 0; a < 2**AW; a++) begin
      @(negedge clock_in);
      rd_addr_in = AW'(a);
      @(negedge clock_in);
      check(rd_data, ERASED_BYTE);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_auto();
    int cycles;
    ctrl_in = 8'he5; // area 2, busy bit of the input deliberately clear
    u_cpu.write_seq('{CMD_AUTO, CMD_AUTO});
    @(negedge clock_in);
    check({7'h0, busy}, 8'h01);
    check(ctrl_status, {ctrl_in[7:2], 1'b1, ctrl_in[0]});
    check({7'h0, wdt_hold}, 8'h01);
    check(wdt_value, WDT_PRESET);
    check({7'h0, read_mode}, 8'h00);
    // an abort during the run is ignored, the erase carries on
    u_cpu.write_seq('{CMD_ABORT, CMD_ABORT});
    check({7'h0, busy}, 8'h01);
    // the first addresses of the area are already zero-filled by now
    rd_addr_in = '0;
    @(negedge clock_in);
    check(rd_data, ZERO_BYTE);
    u_cpu.poll(cycles);
    // busy spans fill, erase and one verify per address; polling began five cycles in
    check(8'(cycles), 8'(2 * 2**AW + EN - 5));
    check({7'h0, cycles < 1000}, 8'h01);
    check_idle();
    check(wdt_value, 8'h00);
    check_array();
  endtask
  task automatic test_abort();
    logic [7:0] first[3] = '{CMD_PROGRAM, CMD_ERASE, CMD_AUTO};
    ctrl_in = 8'h1a; // busy bit set on the input must not show through
    foreach (first[i]) begin
      // after one abort code the cancel is armed, not yet back in read mode
      u_cpu.write_seq('{first[i], CMD_ABORT});
      check({7'h0, read_mode}, 8'h00);
      u_cpu.write_seq('{CMD_ABORT});
      @(negedge clock_in);
      check_idle();
      check_array();
    end
  endtask
  task automatic test_mismatch();
    ctrl_in = 8'h30;
    u_cpu.write_seq('{CMD_AUTO, CMD_READ});
    @(negedge clock_in);
    check_idle();
    check_array();
  endtask
  // ****************************************************************
  // verdict, watchdog and main sequence
  // ****************************************************************
  task automatic results();
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    results();
  end
  initial begin
    repeat (20) @(negedge clock_in);
    rstn_in = 1'b1;
    @(negedge clock_in);
    check_idle();
    test_auto();
    test_abort();
    test_mismatch();
    results();
  end
endmodule
